// ---- shared/i2c_cond_pkg.sv ----
/*
 * Shared constants and carrier types for the I2C-mode condition and event block.
 * Assumes a system clock domain (clk) and a link clock domain driven by the baud
 * count source; all counts below are in link clock cycles.
 */
// Summary of operation
// - select 0: start or stop detect interrupts
// - select 1: own start or stop detect
// - bus busy set at start SDA fall
// - bus busy cleared at stop SDA rise
// - slave start reinitialises channel when enabled
// - receive interrupt at eighth SCL falling edge
// - clock delay loads receive buffer twice
// - clock delay: transmit interrupt at ninth fall
// - generated start/stop hold half SCL period
// - slave conditions need six cycle setup/hold
// - ACK output enable drives ACK value bit
// - clock delay: ninth hold keeps SCL low until cleared
package i2c_cond_pkg;

  localparam logic [2:0] COND_SETUP_CYC = 3'h6;
  localparam logic [2:0] COND_HOLD_CYC  = 3'h6;
  localparam logic [2:0] STAB_MAX       = 3'h7;
  localparam logic [3:0] LAST_DATA_BIT  = 4'h7;
  localparam logic [3:0] ACK_BIT        = 4'h8;
  localparam int         DLY_STAGES     = 7;
  localparam logic [8:0] TX_WORD_RST    = 9'h1ff;
  localparam logic [8:0] RX_WORD_RST    = 9'h000;
  localparam logic       BUSY_RST       = 1'b0;
  localparam logic       TX_EMPTY_RST   = 1'b1;
  localparam int         EV_SS          = 0;
  localparam int         EV_RX          = 1;
  localparam int         EV_TX          = 2;
  localparam int         EV_LD          = 3;
  localparam int         NUM_IRQ        = 3;

  typedef struct packed {
    logic       master_mode;
    logic       cond_output_select;
    logic       start_triggered_init;
    logic       clock_delay_enable;
    logic       ack_value_bit;
    logic       ack_output_enable;
    logic       ninth_bit_scl_hold;
    logic       eighth_bit_scl_hold;
    logic       start_req;
    logic       stop_req;
    logic [2:0] sda_delay_select;
    logic [7:0] scl_half_count;
  } ctrl_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } pin_in_t;

  typedef struct packed {
    logic scl_out;
    logic scl_oe;
    logic sda_out;
    logic sda_oe;
  } pin_out_t;

  typedef enum logic [2:0] {M_IDLE, M_START, M_RUN, M_STOP_LO, M_STOP_HI} mst_t;

endpackage

// ---- hw/sync_bit.sv ----
/*
 * Two-flop level synchroniser, any width.
 * Assumes multi-bit inputs are quasi-static or tolerate per-bit skew.
 */
`timescale 1ns/10ps
module sync_bit #(
  parameter int W = 1
) (
  // destination clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // level in and synchronised level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// ---- hw/pulse_xfer.sv ----
/*
 * Toggle-based event crossing, one lane per bit.
 * Assumes pulses on a lane are at least three destination cycles apart.
 */
`timescale 1ns/10ps
module pulse_xfer #(
  parameter int W = 1
) (
  // reset for both sides
  input  wire logic         rst_b,
  // source side
  input  wire logic         src_clk,
  input  wire logic [W-1:0] src_pulse,
  // destination side
  input  wire logic         dst_clk,
  output logic      [W-1:0] dst_pulse
);
  logic [W-1:0] tog_r;
  logic [W-1:0] meta_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge src_clk or negedge rst_b) begin
    if (!rst_b) begin
      tog_r <= '0;
    end else begin
      tog_r <= tog_r ^ src_pulse;
    end
  end

  always_ff @(posedge dst_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r    <= '0;
      s2_r      <= '0;
      s3_r      <= '0;
      dst_pulse <= '0;
    end else begin
      meta_r    <= tog_r;
      s2_r      <= meta_r;
      s3_r      <= s2_r;
      dst_pulse <= s2_r ^ s3_r;
    end
  end
endmodule

// ---- hw/i2c_cond_core.sv ----
/*
 * I2C-mode condition, busy and byte event logic of a serial channel.
 * Assumes open-drain pins resolved outside; link_clk is the free-running baud
 * count source; control bits arrive as static levels from the clk domain.
 */
`timescale 1ns/10ps
module i2c_cond_core
  import i2c_cond_pkg::*;
(
  // system domain
  input  wire logic           clk,
  input  wire logic           rst_b,
  // link domain clock
  input  wire logic           link_clk,
  // bus pins
  input  wire pin_in_t        pin_in,
  output pin_out_t            pin_out,
  // software control
  input  wire ctrl_t          ctrl,
  input  wire logic           tx_write,
  input  wire logic [8:0]     tx_data,
  input  wire logic [2:0]     irq_clear,
  // software status
  output logic      [2:0]     irq_pend,
  output logic                bus_busy_flag,
  output logic      [8:0]     receive_buffer,
  output logic                tx_shift_empty_flag
);

  ctrl_t                 lc;
  logic [1:0]            pin_s;
  logic                  scl_s;
  logic                  sda_s;
  logic                  scl_p_r;
  logic                  sda_p_r;
  logic [2:0]            stab_r;
  logic [1:0]            cand_r;
  logic                  start_det;
  logic                  stop_det;
  logic                  scl_fall;
  logic                  eighth_fall;
  logic                  ninth_fall;
  logic                  chan_init;
  logic                  busy_r;
  logic                  busy_s;
  logic                  seen_fall_r;
  logic                  hold9_r;
  logic                  hold8;
  logic                  txw_valid_r;
  logic [3:0]            bit_cnt_r;
  logic [8:0]            rx_sh_r;
  logic [8:0]            rxw_r;
  logic [8:0]            txw_r;
  logic [8:0]            tx_word_r;
  logic                  tx_load;
  logic [3:0]            ev_r;
  logic [3:0]            ev_clk;
  mst_t                  mst_r;
  logic [7:0]            half_r;
  logic                  half_done;
  logic                  m_scl_lo_r;
  logic                  m_sda_lo_r;
  logic                  start_gen_r;
  logic                  sreq_p_r;
  logic                  sda_bit;
  logic                  data_en;
  logic                  sda_lo_raw;
  logic                  sda_lo_del;
  logic [DLY_STAGES-1:0] dly_r;

  ////////////////////////////////////////////////////////////////////////////
  // crossings

  sync_bit #(.W($bits(ctrl_t))) u_ctrl_sync (
    .clk   (link_clk),
    .rst_b (rst_b),
    .d     (ctrl),
    .q     (lc)
  );

  sync_bit #(.W(2)) u_pin_sync (
    .clk   (link_clk),
    .rst_b (rst_b),
    .d     ({pin_in.scl, pin_in.sda}),
    .q     (pin_s)
  );

  sync_bit #(.W(1)) u_busy_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (busy_r),
    .q     (busy_s)
  );

  pulse_xfer #(.W(4)) u_ev_xfer (
    .rst_b     (rst_b),
    .src_clk   (link_clk),
    .src_pulse (ev_r),
    .dst_clk   (clk),
    .dst_pulse (ev_clk)
  );

  pulse_xfer #(.W(1)) u_tx_xfer (
    .rst_b     (rst_b),
    .src_clk   (clk),
    .src_pulse (tx_write),
    .dst_clk   (link_clk),
    .dst_pulse (tx_load)
  );

  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  ////////////////////////////////////////////////////////////////////////////
  // condition detection: both lines must sit still around the SDA edge

  assign start_det = cand_r[0] && scl_s && !sda_s && stab_r == COND_HOLD_CYC;
  assign stop_det  = cand_r[1] && scl_s && sda_s && stab_r == COND_HOLD_CYC;
  assign chan_init = start_det && !lc.master_mode && lc.start_triggered_init;

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_p_r <= 1'b0;
      sda_p_r <= 1'b0;
      stab_r  <= 3'h0;
      cand_r  <= 2'h0;
    end else begin
      scl_p_r <= scl_s;
      sda_p_r <= sda_s;
      if (scl_s != scl_p_r || sda_s != sda_p_r) begin
        stab_r <= 3'h0;
      end else if (stab_r != STAB_MAX) begin
        stab_r <= stab_r + 3'h1;
      end
      if (scl_s && scl_p_r && sda_s != sda_p_r) begin
        cand_r <= (stab_r >= COND_SETUP_CYC) ? {sda_s, !sda_s} : 2'h0;
      end else if (scl_s != scl_p_r) begin
        cand_r <= 2'h0;
      end
    end
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_r <= BUSY_RST;
    end else if (start_det) begin
      busy_r <= 1'b1;
    end else if (stop_det) begin
      busy_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit framing, receive word and transmit word

  assign scl_fall    = scl_p_r && !scl_s && busy_r;
  assign eighth_fall = scl_fall && bit_cnt_r == LAST_DATA_BIT;
  assign ninth_fall  = scl_fall && bit_cnt_r == ACK_BIT;

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_r   <= 4'h0;
      seen_fall_r <= 1'b0;
    end else begin
      // the SCL fall that closes a start is not a data bit; every start restarts the frame
      if (chan_init || start_det || ninth_fall) begin
        bit_cnt_r <= 4'h0;
      end else if (scl_fall && seen_fall_r) begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      if (start_det) begin
        seen_fall_r <= 1'b0;
      end else if (scl_fall) begin
        seen_fall_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_sh_r <= RX_WORD_RST;
      rxw_r   <= RX_WORD_RST;
    end else begin
      if (busy_r && !scl_p_r && scl_s) begin
        rx_sh_r <= {rx_sh_r[7:0], sda_s};
      end
      // first load holds the byte in b7..b0 under a stale b8; the second rotates the ack into b8
      if (eighth_fall) begin
        rxw_r <= rx_sh_r;
      end else if (ninth_fall && lc.clock_delay_enable) begin
        rxw_r <= {rx_sh_r[0], rx_sh_r[8:1]};
      end
    end
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      txw_r       <= TX_WORD_RST;
      txw_valid_r <= 1'b0;
    end else if (tx_load) begin
      txw_r       <= tx_word_r;
      txw_valid_r <= 1'b1;
    end else if (ninth_fall || chan_init) begin
      txw_valid_r <= 1'b0;
    end
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold9_r <= 1'b0;
    end else if (ninth_fall && lc.clock_delay_enable && lc.ninth_bit_scl_hold) begin
      hold9_r <= 1'b1;
    end else if (!lc.ninth_bit_scl_hold || chan_init) begin
      hold9_r <= 1'b0;
    end
  end

  assign hold8 = !lc.master_mode && lc.eighth_bit_scl_hold && busy_r && bit_cnt_r == ACK_BIT;

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      ev_r <= 4'h0;
    end else begin
      ev_r[EV_SS] <= stop_det ||
                     (lc.cond_output_select ? start_gen_r : start_det);
      ev_r[EV_RX] <= eighth_fall;
      ev_r[EV_TX] <= ninth_fall && lc.clock_delay_enable;
      ev_r[EV_LD] <= eighth_fall || (ninth_fall && lc.clock_delay_enable);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master start/stop generation and SCL clocking

  assign half_done = half_r == lc.scl_half_count;

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      mst_r       <= M_IDLE;
      half_r      <= 8'h00;
      m_scl_lo_r  <= 1'b0;
      m_sda_lo_r  <= 1'b0;
      start_gen_r <= 1'b0;
      sreq_p_r    <= 1'b0;
    end else begin
      sreq_p_r    <= lc.start_req;
      start_gen_r <= 1'b0;
      half_r      <= half_done ? half_r : half_r + 8'h01;
      case (mst_r)
        M_IDLE: begin
          half_r <= 8'h00;
          if (lc.start_req && !sreq_p_r && lc.master_mode && !busy_r) begin
            m_sda_lo_r  <= 1'b1;
            start_gen_r <= 1'b1;
            mst_r       <= M_START;
          end
        end
        M_START: begin
          if (half_done) begin
            m_scl_lo_r <= 1'b1;
            m_sda_lo_r <= 1'b0;
            half_r     <= 8'h00;
            mst_r      <= M_RUN;
          end
        end
        M_RUN: begin
          if (lc.stop_req && m_scl_lo_r && bit_cnt_r == 4'h0) begin
            m_sda_lo_r <= 1'b1;
            half_r     <= 8'h00;
            mst_r      <= M_STOP_LO;
          end else if (m_scl_lo_r) begin
            // idle low between bytes until software supplies a word
            if (half_done && (txw_valid_r || bit_cnt_r != 4'h0)) begin
              m_scl_lo_r <= 1'b0;
              half_r     <= 8'h00;
            end
          end else if (!scl_s) begin
            half_r <= 8'h00;
          end else if (half_done) begin
            m_scl_lo_r <= 1'b1;
            half_r     <= 8'h00;
          end
        end
        M_STOP_LO: begin
          if (half_done) begin
            m_scl_lo_r <= 1'b0;
            half_r     <= 8'h00;
            mst_r      <= M_STOP_HI;
          end
        end
        M_STOP_HI: begin
          if (!scl_s) begin
            half_r <= 8'h00;
          end else if (half_done) begin
            m_sda_lo_r <= 1'b0;
            mst_r      <= M_IDLE;
          end
        end
        default: begin
          mst_r <= M_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SDA data path, delay line and pin registers

  assign sda_bit = (bit_cnt_r == ACK_BIT) ?
                   (lc.ack_output_enable ? lc.ack_value_bit : txw_r[8]) :
                   txw_r[LAST_DATA_BIT - bit_cnt_r];
  // data is only driven once SCL has fallen, so a stale bit cannot fake a condition
  assign data_en    = busy_r && seen_fall_r && (mst_r == M_RUN || mst_r == M_IDLE);
  assign sda_lo_raw = m_sda_lo_r || (data_en && !sda_bit);
  assign sda_lo_del = (lc.sda_delay_select == 3'h0) ? sda_lo_raw :
                      dly_r[lc.sda_delay_select - 3'h1];

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      dly_r   <= '0;
      pin_out <= '0;
    end else begin
      dly_r           <= {dly_r[DLY_STAGES-2:0], sda_lo_raw};
      pin_out.scl_out <= 1'b0;
      pin_out.sda_out <= 1'b0;
      pin_out.scl_oe  <= m_scl_lo_r || hold8 || hold9_r;
      pin_out.sda_oe  <= sda_lo_del;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system domain status

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_word_r           <= TX_WORD_RST;
      tx_shift_empty_flag <= TX_EMPTY_RST;
      receive_buffer      <= RX_WORD_RST;
      bus_busy_flag       <= BUSY_RST;
    end else begin
      bus_busy_flag <= busy_s;
      if (tx_write) begin
        tx_word_r <= tx_data;
      end
      if (ev_clk[EV_TX]) begin
        tx_shift_empty_flag <= 1'b1;
      end else if (tx_write) begin
        tx_shift_empty_flag <= 1'b0;
      end
      if (ev_clk[EV_LD]) begin
        receive_buffer <= rxw_r;
      end
    end
  end

  for (genvar i = 0; i < NUM_IRQ; i++) begin : g_irq
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        irq_pend[i] <= 1'b0;
      end else if (ev_clk[i]) begin
        irq_pend[i] <= 1'b1;
      end else if (irq_clear[i]) begin
        irq_pend[i] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_ss_detect: assert property (@(posedge link_clk) disable iff (!rst_b)
    (start_det && !lc.cond_output_select) |=> ev_r[EV_SS]) else $error("start not flagged");
  chk_ss_own: assert property (@(posedge link_clk) disable iff (!rst_b)
    (start_gen_r && lc.cond_output_select) |=> ev_r[EV_SS]) else $error("own start not flagged");
  chk_busy_set: assert property (@(posedge link_clk) disable iff (!rst_b)
    $rose(busy_r) |-> $past(start_det)) else $error("busy rose without start");
  chk_busy_clear: assert property (@(posedge link_clk) disable iff (!rst_b)
    stop_det && !start_det |=> !busy_r) else $error("busy kept after stop");
  chk_init_frame: assert property (@(posedge link_clk) disable iff (!rst_b)
    chan_init |=> bit_cnt_r == 4'h0 && !txw_valid_r) else $error("init missed");
  chk_rx_eighth: assert property (@(posedge link_clk) disable iff (!rst_b)
    ev_r[EV_RX] |-> $past(scl_fall) && $past(bit_cnt_r) == 4'h7) else $error("rx timing");
  chk_rx_twice: assert property (@(posedge link_clk) disable iff (!rst_b)
    ninth_fall && lc.clock_delay_enable |=> rxw_r == {$past(rx_sh_r[0]), $past(rx_sh_r[8:1])})
    else $error("second load wrong");
  chk_tx_ninth: assert property (@(posedge link_clk) disable iff (!rst_b)
    ev_r[EV_TX] |-> $past(bit_cnt_r) == 4'h8 && $past(scl_fall)) else $error("tx timing");
  chk_cond_setup: assert property (@(posedge link_clk) disable iff (!rst_b)
    $rose(cand_r[0]) |-> $past(stab_r) >= 3'h6) else $error("setup too short");
  chk_sda_delay: assert property (@(posedge link_clk) disable iff (!rst_b)
    lc.sda_delay_select == 3'h5 && $past(lc.sda_delay_select, 6) == 3'h5
    |-> pin_out.sda_oe == $past(sda_lo_raw, 6)) else $error("sda delay wrong");
  chk_ack_drive: assert property (@(posedge link_clk) disable iff (!rst_b)
    bit_cnt_r == 4'h8 && lc.ack_output_enable |-> sda_bit == lc.ack_value_bit)
    else $error("ack bit not used");
  chk_hold_ninth: assert property (@(posedge link_clk) disable iff (!rst_b)
    hold9_r |=> pin_out.scl_oe) else $error("scl not held");
  chk_pend_sticky: assert property (@(posedge clk) disable iff (!rst_b)
    irq_pend[EV_RX] && !irq_clear[EV_RX] |=> irq_pend[EV_RX]) else $error("pending lost");

  cov_start: cover property (@(posedge link_clk) disable iff (!rst_b) start_det);
  cov_byte: cover property (@(posedge link_clk) disable iff (!rst_b) ev_r[EV_TX]);
  cov_stop_gen: cover property (@(posedge link_clk) disable iff (!rst_b)
    mst_r == M_STOP_HI ##1 mst_r == M_IDLE);

endmodule

// ---- test/i2c_partner.sv ----
/*
 * Far-side model of the bus: a master that makes start, stop and bit cycles.
 * Assumes pull-ups on both lines and that the device's pull enables come in
 * unresolved; the model resolves the wired-and levels for everyone.
 */
`timescale 1ns/10ps
module i2c_partner (
  // link clock paces every bus phase
  input  wire logic link_clk,
  // device pulls
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  // resolved line levels
  output logic      scl,
  output logic      sda
);
  logic scl_lo;
  logic sda_lo;

  // released lines float up through the pull-ups
  assign scl = ~(scl_lo | scl_oe);
  assign sda = ~(sda_lo | sda_oe);

  initial begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk);
    #3;
  endtask

  // a device hold stretches the low phase; the wait is bounded
  task automatic raise_scl();
    scl_lo = 1'b0;
    for (int i = 0; i < 500 && !scl; i++) tick(1);
    tick(4);
  endtask

  // gap below eight cycles gives a hold too short to count as a start
  task automatic start_cond(input int gap);
    sda_lo = 1'b1;
    tick(gap);
    scl_lo = 1'b1;
    tick(8);
  endtask

  task automatic release_lines();
    sda_lo = 1'b0;
    tick(8);
    raise_scl();
    tick(8);
  endtask

  // data changes only while scl is low; r is the wire level seen mid-high
  task automatic put_bit(input logic b, output logic r);
    sda_lo = ~b;
    tick(8);
    raise_scl();
    r = sda;
    tick(4);
    scl_lo = 1'b1;
    tick(8);
  endtask

  task automatic stop_cond();
    sda_lo = 1'b1;
    tick(8);
    raise_scl();
    tick(4);
    sda_lo = 1'b0;
    tick(8);
  endtask
endmodule

// ---- test/testbench.sv ----
/*
 * Self-checking bench for the condition and byte event block in slave and
 * master roles. Assumes the partner model resolves the bus lines and that
 * status flags settle within a dozen link cycles of a bus event.
 */
`timescale 1ns/10ps
module testbench
  import i2c_cond_pkg::*;
;
  logic       clk;
  logic       rst_b;
  logic       link_clk;
  ctrl_t      ctrl;
  logic       tx_write;
  logic [8:0] tx_data;
  logic [2:0] irq_clear;
  pin_in_t    pins;
  pin_out_t   pin_out;
  logic [2:0] irq_pend;
  logic       bus_busy_flag;
  logic [8:0] receive_buffer;
  logic       tx_shift_empty_flag;
  logic       scl_w;
  logic       sda_w;
  logic [8:0] st;
  logic [8:0] w;
  int         err_count;
  int         check_count;
  int         n;
  logic [8:0] txw [3] = '{9'h1ff, 9'h13c, 9'h0ff};
  logic [7:0] pd  [3] = '{8'ha5, 8'hff, 8'h5a};
  logic [8:0] ex  [3] = '{9'h0a5, 9'h13c, 9'h15a};
  logic [1:0] ak  [3] = '{2'b10, 2'b00, 2'b11};

  assign pins = '{scl: scl_w, sda: sda_w};
  assign st   = {4'h0, tx_shift_empty_flag, bus_busy_flag, irq_pend};

  i2c_cond_core i2c_cond_core_i (
    .clk                 (clk),
    .rst_b               (rst_b),
    .link_clk            (link_clk),
    .pin_in              (pins),
    .pin_out             (pin_out),
    .ctrl                (ctrl),
    .tx_write            (tx_write),
    .tx_data             (tx_data),
    .irq_clear           (irq_clear),
    .irq_pend            (irq_pend),
    .bus_busy_flag       (bus_busy_flag),
    .receive_buffer      (receive_buffer),
    .tx_shift_empty_flag (tx_shift_empty_flag)
  );

  i2c_partner i2c_partner_i (
    .link_clk (link_clk),
    .scl_oe   (pin_out.scl_oe),
    .sda_oe   (pin_out.sda_oe),
    .scl      (scl_w),
    .sda      (sda_w)
  );

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // odd offset keeps the link clock out of step with clk
  initial begin
    link_clk = 1'b0;
    #3;
    forever #16 link_clk = ~link_clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input int v, input int lo, input int hi);
    check_count++;
    if (v < lo || v > hi) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, v, lo);
    end
  endtask

  task automatic lw(input int k);
    repeat (k) @(posedge link_clk);
    @(negedge clk);
  endtask

  task automatic clear_irq();
    irq_clear = 3'h7;
    @(negedge clk);
    irq_clear = 3'h0;
    @(negedge clk);
  endtask

  // counts link cycles from one output edge to the next; both waits bounded
  task automatic span(input logic from_scl, output int k);
    for (int i = 0; i < 300 && (from_scl ? pin_out.scl_oe : !pin_out.sda_oe); i++)
      @(negedge link_clk);
    k = 0;
    while (k < 300 && (from_scl ? pin_out.sda_oe : !pin_out.scl_oe)) begin
      @(negedge link_clk);
      k++;
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    err_count++;
    summarize();
  end

  initial begin
    err_count = 0;
    check_count = 0;
    rst_b = 1'b0;
    ctrl = '0;
    tx_write = 1'b0;
    tx_data = 9'h1ff;
    irq_clear = 3'h0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    lw(12);
    chk(st, 9'h010);
    chk({7'h00, pin_out.scl_out, pin_out.sda_out}, 9'h000);
    $display("test reset done");
    i2c_partner_i.start_cond(2);
    i2c_partner_i.release_lines();
    lw(12);
    chk(st, 9'h010);
    $display("test short hold done");
    ctrl.clock_delay_enable = 1'b1;
    ctrl.ninth_bit_scl_hold = 1'b1;
    ctrl.start_triggered_init = 1'b1;
    lw(8);
    i2c_partner_i.start_cond(8);
    lw(12);
    chk(st, 9'h019);
    clear_irq();
    chk(st, 9'h018);
    for (int r = 0; r < 3; r++) begin
      ctrl.ack_output_enable = ak[r][1];
      ctrl.ack_value_bit = ak[r][0];
      tx_data = txw[r];
      tx_write = 1'b1;
      @(negedge clk);
      tx_write = 1'b0;
      lw(1);
      chk(st, 9'h008);
      for (int i = 7; i >= 0; i--) i2c_partner_i.put_bit(pd[r][i], w[i]);
      lw(8);
      chk(st, 9'h00a);
      i2c_partner_i.put_bit(1'b1, w[8]);
      chk(w, ex[r]);
      lw(12);
      chk(st, 9'h01e);
      chk(receive_buffer, ex[r]);
      chk({8'h00, pin_out.scl_oe}, 9'h001);
      ctrl.ninth_bit_scl_hold = 1'b0;
      lw(8);
      chk({8'h00, pin_out.scl_oe}, 9'h000);
      ctrl.ninth_bit_scl_hold = 1'b1;
      lw(8);
      clear_irq();
    end
    i2c_partner_i.stop_cond();
    lw(12);
    chk(st, 9'h011);
    clear_irq();
    $display("test slave bytes done");
    ctrl.cond_output_select = 1'b1;
    lw(8);
    i2c_partner_i.start_cond(8);
    lw(12);
    chk(st, 9'h018);
    i2c_partner_i.stop_cond();
    lw(12);
    chk(st, 9'h011);
    clear_irq();
    $display("test select done");
    ctrl.master_mode = 1'b1;
    ctrl.scl_half_count = 8'h13;
    for (int d = 0; d <= 5; d += 5) begin
      ctrl.sda_delay_select = d[2:0];
      ctrl.cond_output_select = 1'b1;
      lw(40);
      ctrl.start_req = 1'b1;
      span(1'b0, n);
      rchk(n, 19 - d - (d != 0), 21 - d);
      lw(12);
      chk(st, 9'h019);
      clear_irq();
      ctrl.cond_output_select = 1'b0;
      ctrl.start_req = 1'b0;
      ctrl.stop_req = 1'b1;
      span(1'b1, n);
      // the half period starts once the released SCL is seen high: three link cycles later
      rchk(n, 22 + d, 24 + d + (d != 0));
      lw(12);
      ctrl.stop_req = 1'b0;
      chk(st, 9'h011);
      clear_irq();
    end
    $display("test master conditions done");
    summarize();
  end
endmodule
